// File: diag_pkg.sv
// constants for the diagnostic status and self-test block
package diag_pkg;
  localparam logic [6:0] ADDR_FLASH_WRITE_COUNT = 7'h00;
  localparam logic [6:0] ADDR_MISC_CTRL = 7'h34;
  localparam logic [6:0] ADDR_DIAGNOSTIC_STATUS = 7'h3C;
  localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h3E;
  localparam logic [6:0] ADDR_LOT_LO = 7'h52;
  localparam logic [6:0] ADDR_LOT_HI = 7'h54;
  localparam logic [6:0] ADDR_PART = 7'h56;
  localparam logic [6:0] ADDR_SERIAL = 7'h58;
  localparam logic [15:0] MISC_RESET = 16'h0006;
  localparam logic [15:0] MISC_WMASK = 16'h0C47;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] DIAG_MASK = 16'hFF7C;
  localparam int MISC_DR_LINE = 0;
  localparam int MISC_DR_POL = 1;
  localparam int MISC_DR_EN = 2;
  localparam int MISC_POP = 6;
  localparam int MISC_SELFTEST = 10;
  localparam int MISC_CHECKSUM = 11;
  localparam int DIAG_FLASH_FAIL = 2;
  localparam int DIAG_FRAME_ERR = 3;
  localparam int DIAG_OVERRANGE = 4;
  localparam int DIAG_SELFTEST = 5;
  localparam int DIAG_CHECKSUM = 6;
  localparam int DIAG_ALARM1 = 8;
  localparam int DIAG_ALARM2 = 9;
  localparam int DIAG_GYRO_X = 10;
  localparam int DIAG_ACCL_X = 13;
  localparam int GCMD_BIAS = 0;
  localparam int GCMD_RESTORE = 1;
  localparam int GCMD_FLASH = 3;
  localparam int FRAME_BITS = 16;
  localparam int CLK_HZ = 20_000_000;
  localparam int CHECKSUM_MS = 20;
  localparam int FLASH_MS = 75;
  localparam int CHECKSUM_CYC = CHECKSUM_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam logic [15:0] PART_CODE_DEF = 16'h1234;
  localparam logic [15:0] LOT_LO_DEF = 16'h0001;
  localparam logic [15:0] LOT_HI_DEF = 16'h0002;
  localparam logic [11:0] SERIAL_DEF = 12'h001;
  localparam logic [15:0] SERIAL_MASK = 16'h0FFF;
  localparam int CAL_CYC = 16;
endpackage

// File: diag_properties.sv
// port assertions for the diagnostic block
`timescale 1ns/1ps
module diag_properties #(
  parameter int FLASH_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic st_done,
  input wire logic st_run,
  input wire logic pop_enable,
  input wire logic io_line_one_oe_n,
  input wire logic io_line_two_oe_n,
  input wire logic flash_busy
);
  logic [7:0] idle_r;
  logic [15:0] busy_r;
  // cs_n comes from the link side; slack covers its sync delay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= 8'h00;
      busy_r <= 16'h0000;
    end else begin
      idle_r <= !cs_n ? 8'h00 : (idle_r == 8'hFF ? idle_r : idle_r + 8'h01);
      busy_r <= flash_busy ? busy_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  st_clear_a: assert property ($rose(st_done) |-> ##[1:4] !st_run)
    else $error("self-test run not cleared");
  st_cause_a: assert property ($rose(st_run) |-> idle_r < 8'h0C)
    else $error("self-test started without a write");
  pop_hold_a: assert property (idle_r >= 8'h08 |-> $stable(pop_enable))
    else $error("compensation enable moved while idle");
  dr_excl_a: assert property (!(!io_line_one_oe_n && !io_line_two_oe_n))
    else $error("both io lines driven");
  dr_hold_a: assert property (idle_r >= 8'h08 |-> $stable({io_line_one_oe_n, io_line_two_oe_n}))
    else $error("data-ready line changed while idle");
  flash_cause_a: assert property ($rose(flash_busy) |-> idle_r < 8'h0C)
    else $error("flash update started without a write");
  flash_len_a: assert property ($fell(flash_busy) |-> busy_r >= FLASH_CYCLES - 1)
    else $error("flash update ended early");
  flash_bound_a: assert property (flash_busy |-> busy_r < FLASH_CYCLES + 64)
    else $error("flash update never completes");
  cover property ($fell(st_run));
  cover property ($fell(flash_busy));
  cover property (!io_line_two_oe_n);
endmodule

// File: diag_self_test.sv
// diagnostic status, self-test, identification and flash counter block
`timescale 1ns/1ps
module diag_self_test
  import diag_pkg::*;
#(
  parameter int CHECKSUM_CYCLES = CHECKSUM_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC,
  parameter logic [15:0] PART_CODE = PART_CODE_DEF, // arbitrary value
  parameter logic [15:0] LOT_LO = LOT_LO_DEF,
  parameter logic [15:0] LOT_HI = LOT_HI_DEF,
  parameter logic [11:0] SERIAL = SERIAL_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  input wire logic sample_tick,
  input wire logic data_valid,
  input wire logic st_done,
  input wire logic [5:0] st_fail,
  input wire logic checksum_match,
  input wire logic alarm1,
  input wire logic alarm2,
  input wire logic overrange,
  input wire logic flash_fail,
  output logic st_run,
  output logic pop_enable,
  output logic io_line_one,
  output logic io_line_two,
  output logic io_line_one_oe_n,
  output logic io_line_two_oe_n,
  output logic flash_busy
);

  // ---------------- link domain (sclk) ----------------
  // shifter samples mosi on rising edges, miso changes on falling edges
  logic [15:0] rx_sh_r;
  logic [3:0] bitcnt_r;
  logic frame_tgl_r;
  logic [15:0] frame_word_r;
  logic [15:0] tx_sh_r;
  logic [3:0] fbit_r;
  logic [3:0] len_r;
  logic [15:0] rd_data_s;

  wire [3:0] bitcnt_nxt = bitcnt_r + 4'h1;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bitcnt_r <= 4'h0;
      rx_sh_r <= 16'h0000;
    end else begin
      bitcnt_r <= bitcnt_nxt;
      rx_sh_r <= {rx_sh_r[14:0], mosi};
    end
  end

  // residue of the clock count; it survives cs_n high for the frame check
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      len_r <= 4'h0;
    end else begin
      len_r <= bitcnt_nxt;
    end
  end

  // a full word toggles a flag; the word holds still for ~16 sclk
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_tgl_r <= 1'b0;
      frame_word_r <= 16'h0000;
    end else if (!cs_n && bitcnt_r == 4'hF) begin
      frame_tgl_r <= ~frame_tgl_r;
      frame_word_r <= {rx_sh_r[14:0], mosi};
    end
  end

  // reply shift: loads the prepared read data at the word boundary
  // read data holds still across the gap between words, so no sync here
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_sh_r <= 16'h0000;
      fbit_r <= 4'h0;
    end else begin
      fbit_r <= fbit_r + 4'h1;
      if (fbit_r == 4'h0) begin
        tx_sh_r <= rd_data_s;
      end else begin
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end
  assign miso = tx_sh_r[15];

  // ---------------- system domain ----------------
  logic [2:0] tgl_sync_r;
  logic [1:0] cs_sync_r;
  logic cs_d_r;
  logic [15:0] misc_r;
  logic [15:0] diag_r;
  logic [15:0] fcnt_r;
  logic [15:0] rd_data_r;
  logic [6:0] rd_addr_r;
  logic frame_err_r;
  logic [3:0] gcmd_r;
  logic [31:0] ck_cnt_r;
  logic [31:0] fl_cnt_r;
  logic [4:0] cal_cnt_r;
  logic st_run_r;
  logic pop_r;
  logic dr1_r;
  logic dr2_r;
  logic oe1_r;
  logic oe2_r;
  logic [1:0] st_done_s_r;
  logic st_done_d_r;

  // word flag arrives sampled twice; the word itself is not sampled, stable by the time it is read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgl_sync_r <= 3'h0;
      cs_sync_r <= 2'h3;
      cs_d_r <= 1'b1;
      st_done_s_r <= 2'h0;
      st_done_d_r <= 1'b0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
      cs_sync_r <= {cs_sync_r[0], cs_n};
      cs_d_r <= cs_sync_r[1];
      st_done_s_r <= {st_done_s_r[0], st_done};
      st_done_d_r <= st_done_s_r[1];
    end
  end

  wire word_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
  wire frame_end = cs_sync_r[1] & ~cs_d_r;
  wire [15:0] word = frame_word_r;
  wire is_write = word_evt & word[15];
  wire is_read = word_evt & ~word[15];
  wire [6:0] waddr = word[14:8];
  wire [6:0] wr_reg = {waddr[6:1], 1'b0};
  wire hi_byte = waddr[0];
  wire misc_wr = is_write & (wr_reg == ADDR_MISC_CTRL);
  wire gcmd_wr = is_write & (wr_reg == ADDR_GLOBAL_COMMAND) & ~hi_byte;
  wire done_evt = st_done_s_r[1] & ~st_done_d_r;
  // a read frame pre-loads the reply for the following frame
  wire diag_rd = is_read & (rd_addr_r == ADDR_DIAGNOSTIC_STATUS);

  // residue is idle-stable once cs high has passed the synchroniser
  // limitation: a frame with no clocks reuses the previous residue
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frame_err_r <= 1'b0;
    end else begin
      frame_err_r <= frame_end & (len_r != 4'h0);
    end
  end

  // read address latched from the command word
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_r <= 7'h00;
    end else if (is_read) begin
      rd_addr_r <= {word[14:9], 1'b0};
    end
  end

  // one-hot address decode; odd and unmapped addresses read zero
  wire [6:0] raddr = word[14:8];
  wire hit_fcnt = (raddr == ADDR_FLASH_WRITE_COUNT);
  wire hit_misc = (raddr == ADDR_MISC_CTRL);
  wire hit_diag = (raddr == ADDR_DIAGNOSTIC_STATUS);
  wire hit_gcmd = (raddr == ADDR_GLOBAL_COMMAND);
  wire hit_lot_lo = (raddr == ADDR_LOT_LO);
  wire hit_lot_hi = (raddr == ADDR_LOT_HI);
  wire hit_part = (raddr == ADDR_PART);
  wire hit_serial = (raddr == ADDR_SERIAL);
  wire [15:0] rd_mux =
    ({16{hit_fcnt}} & fcnt_r) |
    ({16{hit_misc}} & misc_r) |
    ({16{hit_diag}} & diag_r) |
    ({16{hit_gcmd}} & {12'h000, gcmd_r}) |
    ({16{hit_lot_lo}} & LOT_LO) |
    ({16{hit_lot_hi}} & LOT_HI) |
    ({16{hit_part}} & PART_CODE) |
    ({16{hit_serial}} & ({4'h0, SERIAL} & SERIAL_MASK));
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 16'h0000;
    end else if (is_read) begin
      rd_data_r <= rd_mux;
    end
  end
  assign rd_data_s = rd_data_r;

  // misc control: byte writes, bits 9..8 kept as host wrote them
  wire [15:0] misc_wdata = hi_byte ? {word[7:0], misc_r[7:0]} : {misc_r[15:8], word[7:0]};
  wire ck_done = misc_r[MISC_CHECKSUM] && ck_cnt_r == 32'(CHECKSUM_CYCLES - 1);
  logic [15:0] misc_nxt;
  always_comb begin
    misc_nxt = misc_r;
    if (misc_wr) begin
      misc_nxt = (misc_wdata & MISC_WMASK) | (misc_wdata & 16'h0300);
    end
    if (done_evt) begin
      misc_nxt[MISC_SELFTEST] = 1'b0;
    end
    if (ck_done) begin
      misc_nxt[MISC_CHECKSUM] = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      misc_r <= MISC_RESET;
    end else begin
      misc_r <= misc_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ck_cnt_r <= 32'h0000_0000;
    end else if (misc_r[MISC_CHECKSUM] && !ck_done) begin
      ck_cnt_r <= ck_cnt_r + 32'h1;
    end else begin
      ck_cnt_r <= 32'h0000_0000;
    end
  end

  // sticky flags: new events win over a clearing read
  logic [15:0] set_v;
  always_comb begin
    set_v = 16'h0000;
    if (done_evt) begin
      set_v[DIAG_SELFTEST] = |st_fail;
      set_v[DIAG_ACCL_X+2:DIAG_GYRO_X] = st_fail;
    end
    set_v[DIAG_CHECKSUM] = ck_done & ~checksum_match;
    set_v[DIAG_FRAME_ERR] = frame_err_r;
    // level conditions reasserted at each sample boundary
    if (sample_tick) begin
      set_v[DIAG_ALARM2] = alarm2;
      set_v[DIAG_ALARM1] = alarm1;
      set_v[DIAG_OVERRANGE] = overrange;
      set_v[DIAG_FLASH_FAIL] = flash_fail;
    end
  end
  // one sticky flop per flag; unused positions hold zero
  for (genvar gi = 0; gi < 16; gi++) begin : g_flag
    if (DIAG_MASK[gi]) begin : g_used
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          diag_r[gi] <= DIAG_RESET[gi];
        end else begin
          diag_r[gi] <= (diag_r[gi] & ~diag_rd) | set_v[gi];
        end
      end
    end else begin : g_unused
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          diag_r[gi] <= 1'b0;
        end else begin
          diag_r[gi] <= 1'b0;
        end
      end
    end
  end

  // global command: calibration bits run first, then flash update
  wire cal_pend = gcmd_r[GCMD_BIAS] | gcmd_r[GCMD_RESTORE];
  wire cal_done = cal_pend && cal_cnt_r == 5'(CAL_CYC - 1);
  wire fl_done = gcmd_r[GCMD_FLASH] && !cal_pend && fl_cnt_r == 32'(FLASH_CYCLES - 1);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gcmd_r <= 4'h0;
      cal_cnt_r <= 5'h00;
      fl_cnt_r <= 32'h0000_0000;
      fcnt_r <= 16'h0000;
    end else begin
      if (gcmd_wr) begin
        gcmd_r <= gcmd_r | {word[GCMD_FLASH], 1'b0, word[GCMD_RESTORE], word[GCMD_BIAS]};
      end else if (cal_done) begin
        gcmd_r[GCMD_RESTORE:GCMD_BIAS] <= 2'b00;
      end else if (fl_done) begin
        gcmd_r[GCMD_FLASH] <= 1'b0;
      end
      cal_cnt_r <= (cal_pend && !cal_done) ? cal_cnt_r + 5'h01 : 5'h00;
      // flash timer cleared to zero while calibration pending
      fl_cnt_r <= (gcmd_r[GCMD_FLASH] && !cal_pend && !fl_done) ? fl_cnt_r + 32'h1 : 32'h0;
      if (fl_done) begin
        fcnt_r <= fcnt_r + 16'h0001;
      end
    end
  end

  // outputs from flops; data-ready takes priority on its line
  wire dr_lvl = misc_r[MISC_DR_POL] ? data_valid : ~data_valid;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_run_r <= 1'b0;
    end else begin
      st_run_r <= misc_r[MISC_SELFTEST];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pop_r <= 1'b0;
    end else begin
      pop_r <= misc_r[MISC_POP];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dr1_r <= 1'b0;
    end else begin
      dr1_r <= dr_lvl;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dr2_r <= 1'b0;
    end else begin
      dr2_r <= dr_lvl;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe1_r <= 1'b1;
    end else begin
      oe1_r <= ~(misc_r[MISC_DR_EN] & ~misc_r[MISC_DR_LINE]);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe2_r <= 1'b1;
    end else begin
      oe2_r <= ~(misc_r[MISC_DR_EN] & misc_r[MISC_DR_LINE]);
    end
  end
  assign st_run = st_run_r;
  assign pop_enable = pop_r;
  assign io_line_one = dr1_r;
  assign io_line_two = dr2_r;
  assign io_line_one_oe_n = oe1_r;
  assign io_line_two_oe_n = oe2_r;
  assign flash_busy = gcmd_r[GCMD_FLASH];

endmodule

// File: spi_host.sv
// host model driving the serial port
`timescale 1ns/1ps
module spi_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // clock stands still between frames; n from 1 to 15 makes a bad frame
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #24 sclk = 1'b0;
      mosi = tx[i];
      #24 sclk = 1'b1;
      rx = {rx[14:0], miso};
    end
    #24 cs_n = 1'b1;
    mosi = ~mosi; // line is driven to the opposite level after the frame, so no stale level
    #300;
  endtask
endmodule

// File: tb_top.sv
// self-checking bench for the diagnostic block
`timescale 1ns/1ps
module tb_top;
  import diag_pkg::*;
  localparam int CK = 100;
  localparam int FL = 20;
  localparam logic [15:0] PC = 16'h5A5A; // arbitrary value
  localparam logic [15:0] LL = 16'h1357;
  localparam logic [15:0] LH = 16'h2468;
  localparam logic [11:0] SN = 12'hFFE;
  logic clk_sys, arst_n, sclk, cs_n, mosi, miso, sample_tick, data_valid, st_done;
  logic checksum_match, alarm1, alarm2, overrange, flash_fail, st_run, pop_enable;
  logic io_line_one, io_line_two, io_line_one_oe_n, io_line_two_oe_n, flash_busy;
  logic [5:0] st_fail;
  logic [15:0] v, c0, s, e;
  logic [7:0] dr [6] = '{8'h46, 8'h04, 8'h07, 8'h05, 8'h00, 8'h06};
  logic [7:0] gc [2] = '{8'h08, 8'h0B};
  int failures, checks;
  diag_self_test #(.CHECKSUM_CYCLES(CK), .FLASH_CYCLES(FL), .PART_CODE(PC), .LOT_LO(LL),
    .LOT_HI(LH), .SERIAL(SN)) uut (.clk_sys, .arst_n, .sclk, .cs_n, .mosi, .miso,
    .sample_tick, .data_valid, .st_done, .st_fail, .checksum_match, .alarm1, .alarm2,
    .overrange, .flash_fail, .st_run, .pop_enable, .io_line_one, .io_line_two,
    .io_line_one_oe_n, .io_line_two_oe_n, .flash_busy);
  spi_host host (.sclk, .cs_n, .mosi, .miso);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a, (a == 7'h35) ? d & 8'hFC : d}, 16, r);
  endtask
  // reply comes in the next word; an unmapped read fills it
  task automatic chk_rd(input logic [6:0] a, input logic [15:0] exp);
    host.xfer({1'b0, a, 8'h00}, 16, v);
    host.xfer(16'h6000, 16, v);
    check(v, exp);
  endtask
  task automatic tick;
    step(1);
    sample_tick = 1'b1;
    step(1);
    sample_tick = 1'b0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    $display("[FAIL] %0t timeout", $time);
    complete_run;
  end
  initial begin
    {arst_n, sample_tick, data_valid, st_done, alarm1, alarm2, overrange, flash_fail} = 8'h00;
    st_fail = 6'h00;
    checksum_match = 1'b1;
    step(2);
    arst_n = 1'b1;
    step(4);
    check({14'h0000, io_line_one_oe_n, io_line_two_oe_n}, 16'h0001);
    wr(ADDR_PART, 8'hFF);
    chk_rd(ADDR_PART, PC);
    chk_rd(ADDR_LOT_LO, LL);
    chk_rd(ADDR_LOT_HI, LH);
    chk_rd(ADDR_SERIAL, {4'h0, SN});
    chk_rd(ADDR_MISC_CTRL, MISC_RESET);
    chk_rd(ADDR_DIAGNOSTIC_STATUS, DIAG_RESET);
    chk_rd(7'h60, 16'h0000);
    $display("test identity done");
    foreach (dr[i]) begin
      wr(ADDR_MISC_CTRL, dr[i]);
      for (int dv = 0; dv < 2; dv++) begin
        step(1);
        data_valid = dv[0];
        step(2);
        s = {12'h000, io_line_one_oe_n, io_line_two_oe_n, pop_enable,
          dr[i][2] & (dr[i][0] ? io_line_two : io_line_one)};
        e = {12'h000, !(dr[i][2] & !dr[i][0]), !(dr[i][2] & dr[i][0]), dr[i][6],
          dr[i][2] & (dv[0] ~^ dr[i][1])};
        check(s, e);
      end
      chk_rd(ADDR_MISC_CTRL, {8'h00, dr[i]});
    end
    $display("test data ready done");
    wr(ADDR_MISC_CTRL + 7'h01, 8'h04);
    step(6);
    check({15'h0000, st_run}, 16'h0001);
    st_fail = 6'b101001;
    st_done = 1'b1;
    step(6);
    st_done = 1'b0;
    check({15'h0000, st_run}, 16'h0000);
    chk_rd(ADDR_MISC_CTRL, 16'h0006);
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'hA420);
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    $display("test self-test done");
    for (int m = 0; m < 2; m++) begin
      step(1);
      checksum_match = m[0];
      wr(ADDR_MISC_CTRL + 7'h01, 8'h08);
      chk_rd(ADDR_MISC_CTRL, 16'h0806);
      step(CK);
      chk_rd(ADDR_MISC_CTRL, 16'h0006);
      chk_rd(ADDR_DIAGNOSTIC_STATUS, {9'h000, !m[0], 6'h00});
    end
    $display("test checksum done");
    {alarm1, alarm2, overrange, flash_fail} = 4'hF;
    tick;
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'h0314);
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'h0000);
    tick;
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'h0314);
    {alarm1, alarm2, overrange, flash_fail} = 4'h0;
    host.xfer(16'h0000, 12, v);
    chk_rd(ADDR_DIAGNOSTIC_STATUS, 16'h0008);
    $display("test flags done");
    host.xfer({1'b0, ADDR_FLASH_WRITE_COUNT, 8'h00}, 16, v);
    host.xfer(16'h6000, 16, c0);
    foreach (gc[i]) begin
      wr(ADDR_GLOBAL_COMMAND, gc[i]);
      step(6);
      check({15'h0000, flash_busy}, 16'h0001);
      for (int k = 0; k < 300 && flash_busy !== 1'b0; k++) step(1);
      check({15'h0000, flash_busy}, 16'h0000);
      if (flash_busy !== 1'b0) complete_run;
      chk_rd(ADDR_GLOBAL_COMMAND, 16'h0000);
      chk_rd(ADDR_FLASH_WRITE_COUNT, c0 + 16'(i + 1));
    end
    $display("test flash done");
    complete_run;
  end
endmodule
bind diag_self_test diag_properties #(.FLASH_CYCLES(FLASH_CYCLES)) chk (.clk_sys, .arst_n,
  .cs_n, .st_done, .st_run, .pop_enable, .io_line_one_oe_n, .io_line_two_oe_n, .flash_busy);
